// *** rtl/can_mailbox_pkg.sv ***
package can_mailbox_pkg;
   localparam int NUM_MB         = 8;
   localparam int MB_W           = 3;
   localparam int ID_W           = 29;
   localparam int PRIO_W         = 4;
   localparam int DLC_W          = 4;
   localparam int DATA_W         = 64;
   localparam int GAP_W          = 16;
   // standard identifiers sit in bits 28..18 of the identifier field
   localparam logic [ID_W-1:0] STD_ID_MASK = 29'h1ffc0000;
   localparam logic [ID_W-1:0] ID_RST      = 29'h00000000;
   localparam logic [ID_W-1:0] MASK_RST    = 29'h1fffffff;
   localparam logic [PRIO_W-1:0] PRIO_RST  = 4'h0;
   // timing: 1 Mbit/s ceiling on a 100 MHz clock
   localparam int CLK_NS         = 10;
   localparam int BIT_NS         = 1000;
   localparam int BIT_CYC        = (BIT_NS + CLK_NS - 1) / CLK_NS;
   localparam int STD_FRAME_BITS = 108;
   localparam int EXT_FRAME_BITS = 128;
   localparam int OVL_BITS       = 14;

   typedef enum logic [2:0]
   {
      MOT_DISABLED,
      MOT_RX,
      MOT_RX_OVR,
      MOT_TX,
      MOT_CONSUMER,
      MOT_PRODUCER
   } mailbox_object_type_t;

   typedef struct packed
   {
      logic [ID_W-1:0]   id;
      logic              ide;
      logic              rtr;
      logic [DLC_W-1:0]  dlc;
      logic [DATA_W-1:0] data;
   } can_frame_t;

   typedef struct packed
   {
      mailbox_object_type_t mailbox_object_type;
      logic [PRIO_W-1:0]    mailbox_tx_priority;
      logic                 extended_id_select;
      logic [ID_W-1:0]      mailbox_identifier_reg;
      logic [ID_W-1:0]      mailbox_acceptance_mask_reg;
   } mailbox_cfg_t;

   localparam mailbox_cfg_t CFG_RST = '{MOT_DISABLED, PRIO_RST, 1'b0, ID_RST, MASK_RST};
endpackage

// *** rtl/can_mailbox_acceptance.sv ***
`timescale 1ns/100ps
// Operation
// - eight independent mailboxes, each with its own active identifier
// - each mailbox picks receive or transmit role via its object type
// - extended select set matches extended ids, clear matches standard only
// - incoming id masked, compared with mailbox id, stored on acceptance
// - duplicate identifiers across mailboxes are legal
// - mailbox identifier may be rewritten at run time
// - receive mailbox keeps first message until next transfer request
// - overwrite mailbox takes the newest matching frame that no free receiver takes
// - consumer sends remote frame per request, stores first answer
// - chained buffers share one id, only the last may overwrite
// - remote, error and overload frames handled without software
// - frames built from and decoded into mailbox contents
// - a detected bus error raises an error frame
// - overload frames add delay between successive frames
// - frame spacing covers 108 standard or 128 extended bits
// - transmit rate never exceeds 1 Mbit/s
// - a matching remote frame is answered with the data frame
// - highest priority pending transmit mailbox goes first
// - producer mailbox sends its data when a matching remote arrives
module can_mailbox_acceptance
   import can_mailbox_pkg::*;
#(
   parameter int STD_FRAME_CYC = STD_FRAME_BITS * BIT_CYC,
   parameter int EXT_FRAME_CYC = EXT_FRAME_BITS * BIT_CYC,
   parameter int OVL_CYC       = OVL_BITS * BIT_CYC
)
(
   input  wire logic              clk_sys_in,
   input  wire logic              rst_n_in,
   input  wire logic              cfg_we_in,
   input  wire logic [MB_W-1:0]   cfg_sel_in,
   input  wire mailbox_cfg_t      cfg_in,
   input  wire logic [DLC_W-1:0]  cfg_dlc_in,
   input  wire logic [DATA_W-1:0] cfg_data_in,
   input  wire logic [NUM_MB-1:0] xfer_req_in,
   input  wire logic              rx_valid_in,
   input  wire can_frame_t        rx_frame_in,
   input  wire logic              bus_error_in,
   input  wire logic              overload_cond_in,
   input  wire logic              tx_ready_in,
   output logic                   tx_valid_out,
   output can_frame_t             tx_frame_out,
   output logic                   err_frame_out,
   output logic                   overload_frame_out,
   output logic [NUM_MB-1:0]      mb_ready_out,
   output logic [NUM_MB-1:0]      mb_overwrite_out,
   output logic [NUM_MB-1:0]      mb_pending_out,
   input  wire logic [MB_W-1:0]   rd_sel_in,
   output can_frame_t             rd_frame_out
);

   function automatic logic id_match(mailbox_cfg_t c, can_frame_t f);
      logic [ID_W-1:0] m;
      m = c.extended_id_select ? c.mailbox_acceptance_mask_reg
                               : (c.mailbox_acceptance_mask_reg & STD_ID_MASK);
      return (c.extended_id_select == f.ide) &&
             ((f.id & m) == (c.mailbox_identifier_reg & m));
   endfunction

   mailbox_cfg_t              cfg      [NUM_MB];
   mailbox_cfg_t              next_cfg [NUM_MB];
   logic [DLC_W-1:0]          dlc      [NUM_MB];
   logic [DLC_W-1:0]          next_dlc [NUM_MB];
   logic [DATA_W-1:0]         data     [NUM_MB];
   logic [DATA_W-1:0]         next_data[NUM_MB];
   logic [NUM_MB-1:0]         await_ans;
   logic [NUM_MB-1:0]         next_await_ans;
   logic [NUM_MB-1:0]         next_ready;
   logic [NUM_MB-1:0]         next_ovr;
   logic [NUM_MB-1:0]         next_pend;
   can_frame_t                next_rd_frame;
   logic                      push_valid;
   can_frame_t                push_frame;
   logic                      fifo_in_ready;
   logic                      acc_found;
   logic [MB_W-1:0]           acc_idx;
   logic                      sel_found;
   logic [MB_W-1:0]           sel_idx;

   // mailbox store, acceptance and transmit scheduling
   always_comb
   begin
      next_ready     = mb_ready_out;
      next_ovr       = mb_overwrite_out;
      next_pend      = mb_pending_out;
      next_await_ans = await_ans;
      push_valid     = 1'b0;
      push_frame     = '0;
      acc_found      = 1'b0;
      acc_idx        = '0;
      sel_found      = 1'b0;
      sel_idx        = '0;
      for (int i = 0; i < NUM_MB; i++)
      begin
         next_cfg[i]  = cfg[i];
         next_dlc[i]  = dlc[i];
         next_data[i] = data[i];
      end
      // lowest priority value wins, lower index breaks ties
      for (int i = 0; i < NUM_MB; i++)
      begin
         if (mb_pending_out[i] && (!sel_found || cfg[i].mailbox_tx_priority <
             cfg[sel_idx].mailbox_tx_priority))
         begin
            sel_found = 1'b1;
            sel_idx   = MB_W'(i);
         end
      end
      if (sel_found && fifo_in_ready)
      begin
         push_valid            = 1'b1;
         push_frame.id         = cfg[sel_idx].mailbox_identifier_reg;
         push_frame.ide        = cfg[sel_idx].extended_id_select;
         push_frame.dlc        = dlc[sel_idx];
         push_frame.rtr        = (cfg[sel_idx].mailbox_object_type == MOT_CONSUMER);
         push_frame.data       = push_frame.rtr ? '0 : data[sel_idx];
         next_pend[sel_idx]    = 1'b0;
         if (!push_frame.rtr)
            next_ready[sel_idx] = 1'b1;
      end
      for (int i = 0; i < NUM_MB; i++)
      begin
         if (cfg_we_in && cfg_sel_in == MB_W'(i))
         begin
            next_cfg[i]       = cfg_in;
            next_dlc[i]       = cfg_dlc_in;
            next_data[i]      = cfg_data_in;
            next_ready[i]     = 1'b0;
            next_ovr[i]       = 1'b0;
            next_pend[i]      = 1'b0;
            next_await_ans[i] = 1'b0;
         end
         else if (xfer_req_in[i])
         begin
            next_ready[i] = 1'b0;
            next_ovr[i]   = 1'b0;
            if (cfg[i].mailbox_object_type == MOT_TX ||
                cfg[i].mailbox_object_type == MOT_CONSUMER)
               next_pend[i] = 1'b1;
            if (cfg[i].mailbox_object_type == MOT_CONSUMER)
               next_await_ans[i] = 1'b1;
         end
      end
      // acceptance runs last so a store wins over a same-cycle clear
      if (rx_valid_in && rx_frame_in.rtr)
      begin
         for (int i = 0; i < NUM_MB; i++)
            if (cfg[i].mailbox_object_type == MOT_PRODUCER && id_match(cfg[i], rx_frame_in))
               next_pend[i] = 1'b1;
      end
      else if (rx_valid_in)
      begin
         // first free receive or waiting consumer; duplicates chain in index order
         for (int i = 0; i < NUM_MB; i++)
         begin
            if (!acc_found && id_match(cfg[i], rx_frame_in) && !mb_ready_out[i] &&
                (cfg[i].mailbox_object_type == MOT_RX ||
                 (cfg[i].mailbox_object_type == MOT_CONSUMER && await_ans[i])))
            begin
               acc_found = 1'b1;
               acc_idx   = MB_W'(i);
            end
         end
         // overwrite only once the chain ahead of it is full
         for (int i = 0; i < NUM_MB; i++)
         begin
            if (!acc_found && id_match(cfg[i], rx_frame_in) &&
                cfg[i].mailbox_object_type == MOT_RX_OVR)
            begin
               acc_found = 1'b1;
               acc_idx   = MB_W'(i);
            end
         end
         if (acc_found)
         begin
            next_cfg[acc_idx].mailbox_identifier_reg = rx_frame_in.id;
            next_dlc[acc_idx]       = rx_frame_in.dlc;
            next_data[acc_idx]      = rx_frame_in.data;
            next_ovr[acc_idx]       = mb_ready_out[acc_idx];
            next_ready[acc_idx]     = 1'b1;
            next_await_ans[acc_idx] = 1'b0;
         end
      end
      next_rd_frame.id   = next_cfg[rd_sel_in].mailbox_identifier_reg;
      next_rd_frame.ide  = next_cfg[rd_sel_in].extended_id_select;
      next_rd_frame.rtr  = 1'b0;
      next_rd_frame.dlc  = next_dlc[rd_sel_in];
      next_rd_frame.data = next_data[rd_sel_in];
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (!rst_n_in)
      begin
         for (int i = 0; i < NUM_MB; i++)
         begin
            cfg[i]  <= CFG_RST;
            dlc[i]  <= '0;
            data[i] <= '0;
         end
         mb_ready_out     <= '0;
         mb_overwrite_out <= '0;
         mb_pending_out   <= '0;
         await_ans        <= '0;
         rd_frame_out     <= '0;
      end
      else
      begin
         for (int i = 0; i < NUM_MB; i++)
         begin
            cfg[i]  <= next_cfg[i];
            dlc[i]  <= next_dlc[i];
            data[i] <= next_data[i];
         end
         mb_ready_out     <= next_ready;
         mb_overwrite_out <= next_ovr;
         mb_pending_out   <= next_pend;
         await_ans        <= next_await_ans;
         rd_frame_out     <= next_rd_frame;
      end
   end

   // two-entry transmit buffer with frame spacing and overload delay
   can_frame_t                q      [2];
   can_frame_t                next_q [2];
   logic [1:0]                cnt;
   logic [1:0]                next_cnt;
   logic [GAP_W-1:0]          gap;
   logic [GAP_W-1:0]          next_gap;
   logic                      ovl_pend;
   logic                      next_ovl_pend;
   logic                      next_tx_valid;
   logic                      pop;

   assign fifo_in_ready = (cnt != 2'd2) || pop;
   assign tx_frame_out  = q[0];

   always_comb
   begin
      pop           = tx_valid_out && tx_ready_in;
      next_q[0]     = q[0];
      next_q[1]     = q[1];
      next_cnt      = cnt;
      next_gap      = (gap != '0) ? gap - GAP_W'(1) : gap;
      next_ovl_pend = ovl_pend || overload_cond_in;
      if (pop)
      begin
         next_q[0] = q[1];
         next_cnt  = cnt - 2'd1;
         // a frame may not leave faster than the bus can carry it
         next_gap  = GAP_W'(q[0].ide ? EXT_FRAME_CYC : STD_FRAME_CYC);
         if (next_ovl_pend)
         begin
            next_gap      = next_gap + GAP_W'(OVL_CYC);
            next_ovl_pend = 1'b0;
         end
      end
      else if (next_ovl_pend && !tx_valid_out && gap == '0 && cnt == '0)
      begin
         next_gap      = GAP_W'(OVL_CYC);
         next_ovl_pend = 1'b0;
      end
      if (push_valid)
      begin
         next_q[next_cnt[0]] = push_frame;
         next_cnt            = next_cnt + 2'd1;
      end
      // valid never drops without ready: gap only grows on a pop or when idle
      next_tx_valid = (next_cnt != '0) && (next_gap == '0);
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (!rst_n_in)
      begin
         q[0]               <= '0;
         q[1]               <= '0;
         cnt                <= '0;
         gap                <= '0;
         ovl_pend           <= 1'b0;
         tx_valid_out       <= 1'b0;
         err_frame_out      <= 1'b0;
         overload_frame_out <= 1'b0;
      end
      else
      begin
         q[0]               <= next_q[0];
         q[1]               <= next_q[1];
         cnt                <= next_cnt;
         gap                <= next_gap;
         ovl_pend           <= next_ovl_pend;
         tx_valid_out       <= next_tx_valid;
         err_frame_out      <= bus_error_in;
         overload_frame_out <= overload_cond_in;
      end
   end

   sequence s_rx_store;
      rx_valid_in && !rx_frame_in.rtr && acc_found;
   endsequence

   property p_store_id;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      s_rx_store |=> mb_ready_out[$past(acc_idx)] &&
         cfg[$past(acc_idx)].mailbox_identifier_reg == $past(rx_frame_in.id);
   endproperty
   a_store_id: assert property (p_store_id) else $error("accepted id not stored");

   property p_rx_hold;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      (cfg[0].mailbox_object_type == MOT_RX && mb_ready_out[0] && !xfer_req_in[0] &&
       !cfg_we_in) |=> $stable(data[0]);
   endproperty
   a_rx_hold: assert property (p_rx_hold) else $error("receive mailbox lost first message");

   property p_ovr_flag;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      s_rx_store ##0 (cfg[acc_idx].mailbox_object_type == MOT_RX_OVR && mb_ready_out[acc_idx])
      |=> mb_overwrite_out[$past(acc_idx)] && data[$past(acc_idx)] == $past(rx_frame_in.data);
   endproperty
   a_ovr_flag: assert property (p_ovr_flag) else $error("overwrite not taken");

   property p_consumer_req;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      (xfer_req_in[5] && !cfg_we_in && cfg[5].mailbox_object_type == MOT_CONSUMER)
      |=> await_ans[5] ##0 (mb_pending_out[5] || cnt != '0);
   endproperty
   a_consumer_req: assert property (p_consumer_req) else $error("consumer request lost");

   property p_producer;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      (rx_valid_in && rx_frame_in.rtr && cfg[4].mailbox_object_type == MOT_PRODUCER &&
       !cfg_we_in && id_match(cfg[4], rx_frame_in)) |=> mb_pending_out[4] ##[0:2] cnt != '0;
   endproperty
   a_producer: assert property (p_producer) else $error("producer did not answer remote");

   property p_prio;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      push_valid |-> (mb_pending_out[2] == 1'b0 ||
         cfg[sel_idx].mailbox_tx_priority <= cfg[2].mailbox_tx_priority);
   endproperty
   a_prio: assert property (p_prio) else $error("lower priority sent first");

   property p_rate;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      (tx_valid_out && tx_ready_in) |=> !tx_valid_out [*8];
   endproperty
   a_rate: assert property (p_rate) else $error("frames closer than bus rate");

   property p_err;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      bus_error_in ##1 !bus_error_in |-> err_frame_out ##1 !err_frame_out;
   endproperty
   a_err: assert property (p_err) else $error("error frame not raised");

   property p_status_clear;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      (xfer_req_in[2] && !(rx_valid_in && acc_found && acc_idx == 3'd2) &&
       !(push_valid && sel_idx == 3'd2)) |=> !mb_ready_out[2];
   endproperty
   a_status_clear: assert property (p_status_clear) else $error("status not cleared");
endmodule

// *** sim/can_node_model.sv ***
`timescale 1ns/100ps
module can_node_model
   import can_mailbox_pkg::*;
#(
   parameter int MIN_GAP = 9
)
(
   input  wire logic       clk_sys_in,
   input  wire logic       rst_n_in,
   input  wire logic       tx_valid_in,
   input  wire can_frame_t tx_frame_in,
   input  wire logic       stall_in,
   output logic            tx_ready_out,
   output can_frame_t      last_frame_out,
   output logic [7:0]      pop_cnt_out,
   output logic            rate_err_out
);
   int gap;
   // a busy node only withholds ready, so a held frame must wait and not vanish
   assign tx_ready_out = !stall_in;
   always_ff @(posedge clk_sys_in)
   begin
      if (!rst_n_in)
      begin
         pop_cnt_out    <= 8'h00;
         last_frame_out <= '0;
         rate_err_out   <= 1'b0;
         gap            <= 0;
      end
      else
      begin
         gap <= gap + 1;
         if (tx_valid_in && tx_ready_out)
         begin
            last_frame_out <= tx_frame_in;
            pop_cnt_out    <= pop_cnt_out + 8'h01;
            gap            <= 0;
            // frames closer than a frame time would beat the bit rate ceiling
            if (pop_cnt_out != 8'h00 && gap < MIN_GAP)
            begin
               rate_err_out <= 1'b1;
            end
         end
      end
   end
endmodule

// *** sim/can_mailbox_acceptance_test.sv ***
`timescale 1ns/100ps
module can_mailbox_acceptance_test
   import can_mailbox_pkg::*;
;
   logic                 clk_sys_in = 1'b0;
   logic                 rst_n_in = 1'b0;
   logic                 cfg_we_in = 1'b0;
   logic [MB_W-1:0]      cfg_sel_in = 3'h0;
   mailbox_cfg_t         cfg_in = CFG_RST;
   logic [DLC_W-1:0]     cfg_dlc_in = 4'h0;
   logic [DATA_W-1:0]    cfg_data_in = 64'h0;
   logic [NUM_MB-1:0]    xfer_req_in = 8'h00;
   logic                 rx_valid_in = 1'b0;
   can_frame_t           rx_frame_in = '0;
   logic                 bus_error_in = 1'b0;
   logic                 overload_cond_in = 1'b0;
   logic                 stall = 1'b1;
   logic                 ext_sel = 1'b0;
   localparam int        STD_GAP = 20;
   logic [MB_W-1:0]      rd_sel_in = 3'h0;
   logic                 tx_ready, tx_valid_out, err_frame_out, overload_frame_out, rate_err;
   can_frame_t           tx_frame_out, rd_frame_out, last_frame;
   logic [NUM_MB-1:0]    mb_ready_out, mb_overwrite_out, mb_pending_out;
   logic [7:0]           pop_cnt;
   int                   error_cnt = 0;
   int                   num_checks = 0;
   localparam logic [ID_W-1:0] ID_A = 29'h048c0000;
   localparam logic [ID_W-1:0] ID_B = 29'h1f040000;
   localparam logic [ID_W-1:0] ID_P = 29'h02a40000;
   localparam logic [ID_W-1:0] ID_Q = 29'h0ffc0000;

   initial
   begin
      forever #5 clk_sys_in = ~clk_sys_in;
   end

   can_mailbox_acceptance #(.STD_FRAME_CYC(STD_GAP), .EXT_FRAME_CYC(24), .OVL_CYC(10))
      can_mailbox_acceptance_inst (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
      .cfg_we_in(cfg_we_in), .cfg_sel_in(cfg_sel_in), .cfg_in(cfg_in), .cfg_dlc_in(cfg_dlc_in),
      .cfg_data_in(cfg_data_in), .xfer_req_in(xfer_req_in), .rx_valid_in(rx_valid_in),
      .rx_frame_in(rx_frame_in), .bus_error_in(bus_error_in),
      .overload_cond_in(overload_cond_in), .tx_ready_in(tx_ready), .tx_valid_out(tx_valid_out),
      .tx_frame_out(tx_frame_out), .err_frame_out(err_frame_out),
      .overload_frame_out(overload_frame_out), .mb_ready_out(mb_ready_out),
      .mb_overwrite_out(mb_overwrite_out), .mb_pending_out(mb_pending_out),
      .rd_sel_in(rd_sel_in), .rd_frame_out(rd_frame_out));

   can_node_model #(.MIN_GAP(STD_GAP)) can_node_model_inst (.clk_sys_in(clk_sys_in),
      .rst_n_in(rst_n_in),
      .tx_valid_in(tx_valid_out), .tx_frame_in(tx_frame_out), .stall_in(stall),
      .tx_ready_out(tx_ready), .last_frame_out(last_frame), .pop_cnt_out(pop_cnt),
      .rate_err_out(rate_err));

   // wide enough that a flag beside a 64-bit payload is not cut off
   task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish();
      if (error_cnt == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic cfg(input mailbox_object_type_t t, input logic [MB_W-1:0] s,
                      input logic [ID_W-1:0] id, input logic [PRIO_W-1:0] p,
                      input logic [DATA_W-1:0] d);
      // an idle edge first, so back-to-back calls never lower and raise in one step
      @(negedge clk_sys_in);
      cfg_in      = '{t, p, ext_sel, id, MASK_RST};
      cfg_sel_in  = s;
      cfg_dlc_in  = 4'h8;
      cfg_data_in = d;
      cfg_we_in   = 1'b1;
      @(negedge clk_sys_in);
      cfg_we_in = 1'b0;
   endtask

   task automatic rx(input logic [ID_W-1:0] id, input logic ide, input logic rtr,
                     input logic [DATA_W-1:0] d);
      @(negedge clk_sys_in);
      rx_frame_in = '{id, ide, rtr, 4'h8, d};
      rx_valid_in = 1'b1;
      @(negedge clk_sys_in);
      rx_valid_in = 1'b0;
   endtask

   task automatic req(input logic [NUM_MB-1:0] r);
      @(negedge clk_sys_in);
      xfer_req_in = r;
      @(negedge clk_sys_in);
      xfer_req_in = 8'h00;
   endtask

   task automatic wait_pops(input logic [7:0] n);
      for (int i = 0; i < 300 && pop_cnt != n; i++)
         @(negedge clk_sys_in);
      chk(pop_cnt, n);
   endtask

   initial
   begin
      #200000;
      error_cnt++;
      tally_and_finish();
   end

   initial
   begin
      repeat (3) @(negedge clk_sys_in);
      rst_n_in = 1'b1;
      chk({tx_valid_out, mb_ready_out, mb_pending_out}, 64'h0);
      // chain of two receivers on one id, the overwrite one last
      cfg(MOT_RX, 3'h0, ID_A, 4'h0, 64'h0);
      cfg(MOT_RX_OVR, 3'h1, ID_A, 4'h0, 64'h0);
      rx(ID_A, 1'b1, 1'b0, 64'hdead); // ext frame to std mailboxes
      chk(mb_ready_out, 8'h00);
      rx(ID_A | 29'h0003ffff, 1'b0, 1'b0, 64'ha1);
      chk(mb_ready_out, 8'h01);
      chk(rd_frame_out.data, 64'ha1);
      chk(rd_frame_out.id, ID_A | 29'h0003ffff);
      rx(ID_A, 1'b0, 1'b0, 64'hb2);
      chk(rd_frame_out.data, 64'ha1);
      chk(mb_ready_out, 8'h03);
      rd_sel_in = 3'h1;
      rx(ID_A, 1'b0, 1'b0, 64'hc3);
      chk(rd_frame_out.data, 64'hc3);
      chk(mb_overwrite_out, 8'h02);
      req(8'h03);
      chk({mb_ready_out, mb_overwrite_out}, 16'h0);
      cfg(MOT_RX, 3'h0, ID_B, 4'h0, 64'h0);
      rd_sel_in = 3'h0;
      rx(ID_B, 1'b0, 1'b0, 64'hd4);
      chk(rd_frame_out.data, 64'hd4);
      // two transmitters queued at once, lower value wins
      cfg(MOT_TX, 3'h2, ID_P, 4'h5, 64'h22);
      cfg(MOT_TX, 3'h3, ID_P, 4'h1, 64'h33);
      req(8'h0c);
      chk(mb_pending_out, 8'h0c);
      repeat (3) @(negedge clk_sys_in);
      chk({tx_valid_out, tx_frame_out.data}, {1'b1, 64'h33});
      chk(mb_ready_out & 8'h0c, 8'h0c);
      stall = 1'b0;
      wait_pops(8'h2);
      chk(last_frame.data, 64'h22);
      cfg(MOT_PRODUCER, 3'h4, ID_P, 4'h0, 64'h44);
      rx(ID_P, 1'b0, 1'b1, 64'h0);
      wait_pops(8'h3);
      chk({last_frame.rtr, last_frame.data}, {1'b0, 64'h44});
      cfg(MOT_CONSUMER, 3'h5, ID_Q, 4'h0, 64'h0);
      req(8'h20);
      wait_pops(8'h4);
      chk({last_frame.rtr, last_frame.id}, {1'b1, ID_Q});
      rd_sel_in = 3'h5;
      rx(ID_Q, 1'b0, 1'b0, 64'h55);
      rx(ID_Q, 1'b0, 1'b0, 64'h66);
      chk(rd_frame_out.data, 64'h55);
      chk(mb_ready_out[5], 1'b1);
      // extended mailbox takes only an exact extended id
      ext_sel = 1'b1;
      cfg(MOT_RX, 3'h6, ID_A | 29'h00001234, 4'h0, 64'h0);
      rx(ID_A | 29'h00001235, 1'b1, 1'b0, 64'h77);
      chk(mb_ready_out[6], 1'b0);
      rx(ID_A | 29'h00001234, 1'b1, 1'b0, 64'h88);
      chk(mb_ready_out[6], 1'b1);
      bus_error_in = 1'b1;
      @(negedge clk_sys_in);
      bus_error_in = 1'b0;
      chk(err_frame_out, 1'b1);
      overload_cond_in = 1'b1;
      @(negedge clk_sys_in);
      overload_cond_in = 1'b0;
      chk(overload_frame_out, 1'b1);
      chk(rate_err, 1'b0);
      tally_and_finish();
   end
endmodule
